// >>> hw/ppio_defines.vh
// Constants for the two-port parallel I/O block: register indices, resets, fields, timing.
`ifndef PPIO_DEFINES_VH
`define PPIO_DEFINES_VH

// Register indices; the APB byte address is four times the index.
`define PPIO_IDX_P2_OPEN_DRAIN   16'hf1c2
`define PPIO_IDX_P2_DATA         16'hffc0
`define PPIO_IDX_P2_DIR          16'hffc2
`define PPIO_IDX_P1L_DATA        16'hff04
`define PPIO_IDX_P1H_DATA        16'hff06
`define PPIO_IDX_P1L_DIR         16'hf104
`define PPIO_IDX_P1H_DIR         16'hf106
`define PPIO_IDX_IRQ_STATUS      16'hff10
`define PPIO_IDX_IRQ_MASK        16'hff12

// Reset values.
`define PPIO_RST_HALF            8'h00
`define PPIO_RST_WORD            16'h0000
`define PPIO_RST_IRQ             4'h0

// Field positions.
`define PPIO_HALF_MSB            7
`define PPIO_CAP_LSB             12
`define PPIO_CAP_MSB             15

// Capture lines are sampled once every this many clock cycles.
`define PPIO_CAP_SAMPLE_CYCLES   8
`define PPIO_CAP_CNT_LAST        3'h7

`endif

// >>> hw/ppio_capture_sampler.v
// Slow sampler and change detector for the four capture-capable lines.
`timescale 1ns/1ps
`include "ppio_defines.vh"

module ppio_capture_sampler (
    input  wire       sys_clk_in,
    input  wire       rst_in,
    input  wire [3:0] lines_in,
    output reg  [3:0] sampled_out,
    output reg  [3:0] change_out
);

    reg [2:0] div_cnt_r;
    reg       sample_en_r;

    // Divider gives one enable pulse every eight clock cycles.
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            div_cnt_r   <= 3'h0;
            sample_en_r <= 1'b0;
        end else begin
            div_cnt_r   <= div_cnt_r + 3'h1;
            sample_en_r <= (div_cnt_r == `PPIO_CAP_CNT_LAST);
        end
    end

    // Lines are looked at only on the enable, so short glitches between samples are missed.
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            sampled_out <= 4'h0;
            change_out  <= 4'h0;
        end else if (sample_en_r) begin
            sampled_out <= lines_in;
            change_out  <= lines_in ^ sampled_out;
        end else begin
            change_out  <= 4'h0;
        end
    end

endmodule // ppio_capture_sampler

// >>> hw/ppio_top.v
// Two 16-bit parallel I/O ports with APB registers, address-bus takeover and capture interrupts.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "ppio_defines.vh"

module ppio_top (
    input  wire        sys_clk_in,
    input  wire        rst_in,
    // APB slave.
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [17:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    // Bus controller, same clock.
    input  wire        bc_ext_bus_en_in,
    input  wire        bc_demux_sel_in,
    input  wire        bc_access_in,
    input  wire [15:0] bc_addr_in,
    // Port one pins.
    input  wire [15:0] p1_pin_in,
    output wire [15:0] p1_pin_out,
    output wire [15:0] p1_pin_oe_out,
    // Port two pins and alternate output source.
    input  wire [15:0] p2_pin_in,
    output wire [15:0] p2_pin_out,
    output wire [15:0] p2_pin_oe_out,
    input  wire [15:0] p2_alt_en_in,
    input  wire [15:0] p2_alt_data_in,
    // Capture lines to the second capture unit, and interrupt.
    output wire [3:0]  upper_capture_inputs_out,
    output wire        irq_out
);

    // Decodes an APB address against a register index.
    function reg_hit;
        input [17:0] addr;
        input [15:0] idx;
        begin
            reg_hit = (addr[17:2] == idx) && (addr[1:0] == 2'b00);
        end
    endfunction

    reg  [7:0]  port1_low_half_data_r;
    reg  [7:0]  port1_high_half_data_r;
    reg  [7:0]  port1_low_half_direction_r;
    reg  [7:0]  port1_high_half_direction_r;
    reg  [15:0] port2_line_data_r;
    reg  [15:0] port2_line_direction_r;
    reg  [15:0] port2_open_drain_select_r;
    reg  [3:0]  irq_status_r;
    reg  [3:0]  irq_mask_r;
    reg  [15:0] p1_sync1_r;
    reg  [15:0] p1_sync2_r;
    reg  [15:0] p2_sync1_r;
    reg  [15:0] p2_sync2_r;
    reg  [31:0] rdata_nxt;

    wire        setup_phase;
    wire        access_phase;
    wire        wr_en;
    wire        addr_mapped;
    wire        p1_bus_active;
    wire [15:0] p1_latch;
    wire [3:0]  cap_change;
    wire [3:0]  irq_status_nxt;

    // APB phases; the slave never inserts wait states.
    assign setup_phase  = psel_in & ~penable_in;
    assign access_phase = psel_in & penable_in;
    assign wr_en        = access_phase & pwrite_in & addr_mapped;
    assign pready_out   = access_phase;
    assign pslverr_out  = access_phase & ~addr_mapped;

    // Address map shared by read and write paths.
    assign addr_mapped = reg_hit(paddr_in, `PPIO_IDX_P2_OPEN_DRAIN)
                       | reg_hit(paddr_in, `PPIO_IDX_P2_DATA)
                       | reg_hit(paddr_in, `PPIO_IDX_P2_DIR)
                       | reg_hit(paddr_in, `PPIO_IDX_P1L_DATA)
                       | reg_hit(paddr_in, `PPIO_IDX_P1H_DATA)
                       | reg_hit(paddr_in, `PPIO_IDX_P1L_DIR)
                       | reg_hit(paddr_in, `PPIO_IDX_P1H_DIR)
                       | reg_hit(paddr_in, `PPIO_IDX_IRQ_STATUS)
                       | reg_hit(paddr_in, `PPIO_IDX_IRQ_MASK);

    // Pins come from outside the clock domain, so each passes two flip-flops.
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            p1_sync1_r <= `PPIO_RST_WORD;
            p1_sync2_r <= `PPIO_RST_WORD;
            p2_sync1_r <= `PPIO_RST_WORD;
            p2_sync2_r <= `PPIO_RST_WORD;
        end else begin
            p1_sync1_r <= p1_pin_in;
            p1_sync2_r <= p1_sync1_r;
            p2_sync1_r <= p2_pin_in;
            p2_sync2_r <= p2_sync1_r;
        end
    end

    // Only a demultiplexed mode claims port one; multiplexed-only modes leave it alone.
    assign p1_bus_active = bc_ext_bus_en_in & bc_demux_sel_in;

    // Port one output latch: its input is muxed between the APB and the bus address.
    // Software writes are dropped in bus mode, which is one safe reading of the hazard.
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            port1_low_half_data_r  <= `PPIO_RST_HALF;
            port1_high_half_data_r <= `PPIO_RST_HALF;
        end else if (p1_bus_active) begin
            if (bc_access_in) begin
                port1_low_half_data_r  <= bc_addr_in[7:0];
                port1_high_half_data_r <= bc_addr_in[15:8];
            end
        end else if (wr_en) begin
            if (reg_hit(paddr_in, `PPIO_IDX_P1L_DATA)) begin
                port1_low_half_data_r <= pwdata_in[`PPIO_HALF_MSB:0];
            end
            if (reg_hit(paddr_in, `PPIO_IDX_P1H_DATA)) begin
                port1_high_half_data_r <= pwdata_in[`PPIO_HALF_MSB:0];
            end
        end
    end

    // Direction registers keep the software value through bus mode.
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            port1_low_half_direction_r  <= `PPIO_RST_HALF;
            port1_high_half_direction_r <= `PPIO_RST_HALF;
            port2_line_direction_r      <= `PPIO_RST_WORD;
        end else if (wr_en) begin
            if (reg_hit(paddr_in, `PPIO_IDX_P1L_DIR)) begin
                port1_low_half_direction_r <= pwdata_in[`PPIO_HALF_MSB:0];
            end
            if (reg_hit(paddr_in, `PPIO_IDX_P1H_DIR)) begin
                port1_high_half_direction_r <= pwdata_in[`PPIO_HALF_MSB:0];
            end
            if (reg_hit(paddr_in, `PPIO_IDX_P2_DIR)) begin
                port2_line_direction_r <= pwdata_in[15:0];
            end
        end
    end

    // Port two data and open-drain registers.
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            port2_line_data_r         <= `PPIO_RST_WORD;
            port2_open_drain_select_r <= `PPIO_RST_WORD;
        end else if (wr_en) begin
            if (reg_hit(paddr_in, `PPIO_IDX_P2_DATA)) begin
                port2_line_data_r <= pwdata_in[15:0];
            end
            if (reg_hit(paddr_in, `PPIO_IDX_P2_OPEN_DRAIN)) begin
                port2_open_drain_select_r <= pwdata_in[15:0];
            end
        end
    end

    // Port one pins: the bus controller forces all outputs on in address mode,
    // and the stored direction returns as soon as the mode drops.
    assign p1_latch      = {port1_high_half_data_r, port1_low_half_data_r};
    assign p1_pin_out    = p1_latch;
    assign p1_pin_oe_out = p1_bus_active ? 16'hffff
                         : {port1_high_half_direction_r,
                            port1_low_half_direction_r};

    // Port two pins, one driver per line.
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_p2_drv
            wire drv_val;
            // Alternate data is ANDed in, so software must hold the latch at one.
            assign drv_val = port2_line_data_r[gi]
                           & (~p2_alt_en_in[gi] | p2_alt_data_in[gi]);
            assign p2_pin_out[gi] = drv_val;
            // Open-drain lines only pull low and float when driving a one.
            assign p2_pin_oe_out[gi] = port2_line_direction_r[gi]
                & (~port2_open_drain_select_r[gi] | ~drv_val);
        end
    endgenerate

    // Capture lines are the synchronised pin levels, which in address mode
    // reflect the driven address, so address changes can still interrupt.
    ppio_capture_sampler u_cap (
        .sys_clk_in  (sys_clk_in),
        .rst_in      (rst_in),
        .lines_in    (p1_sync2_r[`PPIO_CAP_MSB:`PPIO_CAP_LSB]),
        .sampled_out (upper_capture_inputs_out),
        .change_out  (cap_change)
    );

    // Sticky status: a new change wins over a write-one-to-clear in the same cycle.
    assign irq_status_nxt = (wr_en && reg_hit(paddr_in, `PPIO_IDX_IRQ_STATUS))
                          ? (irq_status_r & ~pwdata_in[3:0]) : irq_status_r;

    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            irq_status_r <= `PPIO_RST_IRQ;
            irq_mask_r   <= `PPIO_RST_IRQ;
        end else begin
            irq_status_r <= irq_status_nxt | cap_change;
            if (wr_en && reg_hit(paddr_in, `PPIO_IDX_IRQ_MASK)) begin
                irq_mask_r <= pwdata_in[3:0];
            end
        end
    end

    assign irq_out = |(irq_status_r & irq_mask_r);

    // Read mux; reserved and unmapped bits read as zero.
    always @* begin
        rdata_nxt = 32'h0000_0000;
        if (reg_hit(paddr_in, `PPIO_IDX_P1L_DATA)) begin
            rdata_nxt[7:0] = p1_sync2_r[7:0];
        end else if (reg_hit(paddr_in, `PPIO_IDX_P1H_DATA)) begin
            rdata_nxt[7:0] = p1_sync2_r[15:8];
        end else if (reg_hit(paddr_in, `PPIO_IDX_P1L_DIR)) begin
            rdata_nxt[7:0] = port1_low_half_direction_r;
        end else if (reg_hit(paddr_in, `PPIO_IDX_P1H_DIR)) begin
            rdata_nxt[7:0] = port1_high_half_direction_r;
        end else if (reg_hit(paddr_in, `PPIO_IDX_P2_DATA)) begin
            rdata_nxt[15:0] = p2_sync2_r;
        end else if (reg_hit(paddr_in, `PPIO_IDX_P2_DIR)) begin
            rdata_nxt[15:0] = port2_line_direction_r;
        end else if (reg_hit(paddr_in, `PPIO_IDX_P2_OPEN_DRAIN)) begin
            rdata_nxt[15:0] = port2_open_drain_select_r;
        end else if (reg_hit(paddr_in, `PPIO_IDX_IRQ_STATUS)) begin
            rdata_nxt[3:0] = irq_status_r;
        end else if (reg_hit(paddr_in, `PPIO_IDX_IRQ_MASK)) begin
            rdata_nxt[3:0] = irq_mask_r;
        end
    end

    // Read data is captured in the setup cycle so it stands registered in the access cycle.
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (setup_phase && !pwrite_in) begin
            prdata_out <= rdata_nxt;
        end
    end

endmodule // ppio_top

// >>> test/ppio_chk.sv
// Concurrent checks on the parallel I/O block's top-level ports.
`timescale 1ns/1ps
module ppio_chk (
    input wire        sys_clk_in, rst_in, psel_in, penable_in, pwrite_in,
    input wire [17:0] paddr_in,
    input wire        pready_out, pslverr_out, bc_ext_bus_en_in, bc_demux_sel_in, bc_access_in,
    input wire [15:0] bc_addr_in, p1_pin_out, p1_pin_oe_out, p2_pin_out, p2_pin_oe_out,
    input wire [15:0] p2_alt_en_in, p2_alt_data_in,
    input wire [3:0]  upper_capture_inputs_out,
    input wire        irq_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // Demultiplexed mode in force; the bus controller then owns port one.
    wire demux_on = bc_ext_bus_en_in && bc_demux_sel_in;
    // The slave has no wait states, so every access phase is answered at once.
    apb_ready_a:
        assert property (psel_in && penable_in |-> pready_out) else $error("pready missing");
    apb_align_a:
        assert property (psel_in && penable_in && paddr_in[1:0] != 2'h0 |-> pslverr_out)
        else $error("misaligned access not refused");
    demux_oe_a:
        assert property (demux_on |-> p1_pin_oe_out == 16'hffff) else $error("port one not driven");
    addr_drive_a:
        assert property (demux_on && bc_access_in |=> p1_pin_out == $past(bc_addr_in))
        else $error("address not on port one");
    latch_hold_a:
        assert property (!(psel_in && penable_in && pwrite_in) && !(demux_on && bc_access_in)
            |=> $stable(p1_pin_out)) else $error("port one latch moved by itself");
    cap_rate_a:
        assert property (!$stable(upper_capture_inputs_out) |=> $stable(upper_capture_inputs_out)[*7])
        else $error("capture lines sampled too often");
    reset_state_a:
        assert property ($fell(rst_in) && !bc_ext_bus_en_in |-> p1_pin_oe_out == 16'h0000
            && p2_pin_oe_out == 16'h0000 && !irq_out) else $error("lines not inputs after reset");
    alt_and_a:
        assert property ((p2_pin_out & p2_alt_en_in & ~p2_alt_data_in) == 16'h0000)
        else $error("alternate data not combined by and");
endmodule // ppio_chk

bind ppio_top ppio_chk ppio_chk_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .bc_ext_bus_en_in(bc_ext_bus_en_in),
    .bc_demux_sel_in(bc_demux_sel_in), .bc_access_in(bc_access_in), .bc_addr_in(bc_addr_in),
    .p1_pin_out(p1_pin_out), .p1_pin_oe_out(p1_pin_oe_out), .p2_pin_out(p2_pin_out),
    .p2_pin_oe_out(p2_pin_oe_out), .p2_alt_en_in(p2_alt_en_in), .p2_alt_data_in(p2_alt_data_in),
    .upper_capture_inputs_out(upper_capture_inputs_out), .irq_out(irq_out));

// >>> test/ppio_board_model.sv
// Board model: resolves the port pins from the block's drivers and the outside world.
`timescale 1ns/1ps
module ppio_board_model (
    input  wire [15:0] p1_out_in, p1_oe_in, p2_out_in, p2_oe_in, ext_p1_in, ext_p2_in,
    input  wire        addr_mode_in,
    output wire [15:0] p1_level_out, p2_level_out
);
    // Outside drivers back off while port one carries addresses; an undriven line then shows
    // the inverse of the latch, so a stale value can never pass for a good one.
    wire [15:0] p1_ext = addr_mode_in ? ~p1_out_in : ext_p1_in;
    // A line driven by the block follows the block's output value, otherwise the outside level.
    assign p1_level_out = (p1_oe_in & p1_out_in) | (~p1_oe_in & p1_ext);
    assign p2_level_out = (p2_oe_in & p2_out_in) | (~p2_oe_in & ext_p2_in);
endmodule // ppio_board_model

// >>> test/ppio_top_bench.sv
// Self-checking testbench for the parallel I/O block.
`timescale 1ns/1ps
`include "ppio_defines.vh"
module ppio_top_bench;
    logic        sys_clk_in, rst_in, psel_in, penable_in, pwrite_in, err;
    logic        bc_ext_bus_en_in, bc_demux_sel_in, bc_access_in;
    logic [17:0] paddr_in;
    logic [1:0]  lsb;
    logic [31:0] pwdata_in, rd;
    logic [15:0] bc_addr_in, p2_alt_en_in, p2_alt_data_in, ext_p1, ext_p2;
    wire  [31:0] prdata_out;
    wire         pready_out, pslverr_out, irq_out;
    wire  [15:0] p1_pin_in, p1_pin_out, p1_pin_oe_out, p2_pin_in, p2_pin_out, p2_pin_oe_out;
    wire  [3:0]  upper_capture_inputs_out;
    int          num_errors, n_checks, cycles, i;
    logic [15:0] idx_list [0:8] = '{`PPIO_IDX_P2_OPEN_DRAIN, `PPIO_IDX_P2_DATA, `PPIO_IDX_P2_DIR,
        `PPIO_IDX_P1L_DATA, `PPIO_IDX_P1H_DATA, `PPIO_IDX_P1L_DIR, `PPIO_IDX_P1H_DIR,
        `PPIO_IDX_IRQ_STATUS, `PPIO_IDX_IRQ_MASK};

    ppio_top ppio_top_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .bc_ext_bus_en_in(bc_ext_bus_en_in), .bc_demux_sel_in(bc_demux_sel_in),
        .bc_access_in(bc_access_in), .bc_addr_in(bc_addr_in), .p1_pin_in(p1_pin_in),
        .p1_pin_out(p1_pin_out), .p1_pin_oe_out(p1_pin_oe_out), .p2_pin_in(p2_pin_in),
        .p2_pin_out(p2_pin_out), .p2_pin_oe_out(p2_pin_oe_out), .p2_alt_en_in(p2_alt_en_in),
        .p2_alt_data_in(p2_alt_data_in), .upper_capture_inputs_out(upper_capture_inputs_out),
        .irq_out(irq_out));
    ppio_board_model ppio_board_model_inst (.p1_out_in(p1_pin_out), .p1_oe_in(p1_pin_oe_out),
        .p2_out_in(p2_pin_out), .p2_oe_in(p2_pin_oe_out), .ext_p1_in(ext_p1), .ext_p2_in(ext_p2),
        .addr_mode_in(bc_ext_bus_en_in && bc_demux_sel_in), .p1_level_out(p1_pin_in),
        .p2_level_out(p2_pin_in));

    // Free-running clock at 25 MHz.
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    // A hang is cut short well past the few hundred cycles the tests need.
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    task results;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request stands until pready is seen high at a rising edge.
    // Only the global cycle ceiling ends a wait, so a missing answer is always counted.
    task apb(input w, input [15:0] idx, input [31:0] wd);
        psel_in <= 1'b1; pwrite_in <= w; paddr_in <= {idx, lsb}; pwdata_in <= wd;
        @(posedge sys_clk_in); penable_in <= 1'b1;
        do @(posedge sys_clk_in); while (pready_out !== 1'b1);
        rd = prdata_out; err = pslverr_out;
        psel_in <= 1'b0; penable_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task wr(input [15:0] idx, input [31:0] d); apb(1'b1, idx, d); endtask
    task rdc(input [15:0] idx, input [31:0] exp); apb(1'b0, idx, 32'h0); chk(rd, exp); endtask
    // Leaves time for the pin synchroniser and one full capture sampling period.
    task settle; repeat (24) @(posedge sys_clk_in); endtask

    task t_reset;
        chk(p1_pin_oe_out, 16'h0); chk(p2_pin_oe_out, 16'h0);
        chk(p2_pin_out, 16'h0);
        // Data registers read the pin levels; undriven port two lines sit at the board level.
        for (i = 0; i < 9; i++)
            rdc(idx_list[i], (idx_list[i] == `PPIO_IDX_P2_DATA) ? 32'hffff : 32'h0);
        apb(1'b0, 16'h0001, 32'h0); chk(err, 1'b1); chk(rd, 32'h0);
        // A misaligned access is refused and a misaligned write leaves the register alone.
        lsb = 2'b01; apb(1'b0, `PPIO_IDX_P2_DIR, 32'h0); chk(err, 1'b1); chk(rd, 32'h0);
        wr(`PPIO_IDX_P2_DIR, 32'hffff); lsb = 2'b00; chk(err, 1'b1);
        rdc(`PPIO_IDX_P2_DIR, 32'h0);
        $display("reset values done");
    endtask
    task t_port2;
        wr(`PPIO_IDX_P2_DIR, 32'hffff); wr(`PPIO_IDX_P2_OPEN_DRAIN, 32'h00ff);
        wr(`PPIO_IDX_P2_DATA, 32'hf0f0); chk(p2_pin_out, 16'hf0f0);
        chk(p2_pin_oe_out, 16'hff0f);
        settle; rdc(`PPIO_IDX_P2_DATA, 32'hf0f0); rdc(`PPIO_IDX_P2_OPEN_DRAIN, 32'h00ff);
        p2_alt_en_in <= 16'h00ff; p2_alt_data_in <= 16'h0f0f; @(posedge sys_clk_in);
        @(posedge sys_clk_in); chk(p2_pin_out, 16'hf000); chk(p2_pin_oe_out, 16'hffff);
        $display("port two done");
    endtask
    task t_capture;
        wr(`PPIO_IDX_IRQ_MASK, 32'h0); ext_p1 <= 16'h2000; settle;
        chk(upper_capture_inputs_out, 4'h2); chk(irq_out, 1'b0);
        rdc(`PPIO_IDX_IRQ_STATUS, 32'h2); wr(`PPIO_IDX_IRQ_MASK, 32'hf); chk(irq_out, 1'b1);
        wr(`PPIO_IDX_IRQ_STATUS, 32'h2); chk(irq_out, 1'b0); rdc(`PPIO_IDX_IRQ_STATUS, 32'h0);
        $display("capture done");
    endtask
    task t_halves;
        wr(`PPIO_IDX_P1L_DIR, 32'hff); wr(`PPIO_IDX_P1H_DIR, 32'hff);
        wr(`PPIO_IDX_P1L_DATA, 32'ha5); wr(`PPIO_IDX_P1H_DATA, 32'h3c);
        chk(p1_pin_oe_out, 16'hffff); chk(p1_pin_out, 16'h3ca5);
        wr(`PPIO_IDX_P1L_DATA, 32'hffffff5a); chk(p1_pin_out, 16'h3c5a);
        settle; rdc(`PPIO_IDX_P1L_DATA, 32'h5a); rdc(`PPIO_IDX_P1H_DATA, 32'h3c);
        wr(`PPIO_IDX_P1L_DIR, 32'h0f); chk(p1_pin_oe_out, 16'hff0f);
        wr(`PPIO_IDX_IRQ_STATUS, 32'hf); rdc(`PPIO_IDX_IRQ_STATUS, 32'h0);
        $display("port one halves done");
    endtask
    // Software leaves the port one latch alone while the bus controller owns it.
    task t_bus;
        bc_ext_bus_en_in <= 1'b1; @(posedge sys_clk_in);
        @(posedge sys_clk_in); chk(p1_pin_oe_out, 16'hff0f);
        bc_demux_sel_in <= 1'b1; bc_access_in <= 1'b1; bc_addr_in <= 16'h9a3c;
        @(posedge sys_clk_in); bc_access_in <= 1'b0; @(posedge sys_clk_in);
        @(posedge sys_clk_in); chk(p1_pin_out, 16'h9a3c); chk(p1_pin_oe_out, 16'hffff);
        settle; rdc(`PPIO_IDX_IRQ_STATUS, 32'ha);
        bc_ext_bus_en_in <= 1'b0; bc_demux_sel_in <= 1'b0; @(posedge sys_clk_in);
        @(posedge sys_clk_in); chk(p1_pin_oe_out, 16'hff0f); chk(p1_pin_out, 16'h9a3c);
        $display("bus takeover done");
    endtask

    // Main sequence: every input is set at time zero and reset is held for six cycles.
    initial begin
        num_errors = 0; n_checks = 0; cycles = 0; rst_in = 1'b1; lsb = 2'b00;
        psel_in = 1'b0; penable_in = 1'b0; pwrite_in = 1'b0; paddr_in = 18'h0; pwdata_in = 32'h0;
        bc_ext_bus_en_in = 1'b0; bc_demux_sel_in = 1'b0; bc_access_in = 1'b0; bc_addr_in = 16'h0;
        p2_alt_en_in = 16'h0; p2_alt_data_in = 16'h0; ext_p1 = 16'h0; ext_p2 = 16'hffff;
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0; @(posedge sys_clk_in);
        t_reset(); t_port2(); t_capture(); t_halves(); t_bus();
        results();
    end
endmodule // ppio_top_bench
